// *** panel_regs.svh ***
// panel_regs.svh: offsets, field positions, reset values and timing of the panel controller
// Operation
// - run state lamp on while drive runs, off while stopped.
// - source lamp off for panel, on for terminal, blinking for communication.
// - direction lamp on while reversing, off while running forward.
// - tune lamp on in torque mode, slow blink tuning, fast blink fault.
// - drive a five-digit display with frequencies, monitor data and fault codes.
// - menu level key toggles entry into and exit from the group level.
// - confirm key descends one level, and confirms the value at value level.
// - increment raises, decrement lowers the selected value or code number.
// - shift cycles monitor items, or moves the edited digit at value level.
// - run key starts the drive only under panel command source.
// - stop key stops a running drive, resets a fault, gated by scope setting.
// - multifunction key performs the switchover chosen by its setting.
// - menu has group, code and value levels.
// - confirm at value level stores, then returns selecting the next code.
// - menu key at value level discards the edit, keeps the same code.
// - non-modifiable value shows no blinking digit and ignores edit keys.
// - read-only codes never editable; stop-only codes locked while running.
// - groups P0-P9, PA-PE, A0-A8, AC and U0-U3.
// - visibility units digit shows U groups, tens digit A groups; default 11.
// - in code display, increment and decrement step through the codes.
`ifndef PANEL_REGS_SVH
`define PANEL_REGS_SVH
`define REG_MF_SET 8'h00
`define REG_STOP_SCOPE 8'h04
`define REG_VISIBLE 8'h08
`define REG_STATUS 8'h0C
`define REG_EDIT 8'h10
`define VIS_RESET 8'h11
`define SCOPE_RESET 2'h3
`define VIS_U_BIT 0
`define VIS_A_BIT 4
`define SCOPE_ANY_SRC 0
`define SCOPE_RESET_EN 1
`define GROUPS 29
`define GRP_P_LAST 5'h0E
`define GRP_A_FIRST 5'h0F
`define GRP_A_LAST 5'h18
`define GRP_U_FIRST 5'h19
`define GRP_LAST 5'h1C
`define DG_A 5'h0A
`define DG_C 5'h0C
`define DG_P 5'h10
`define DG_U 5'h11
`define DG_DASH 5'h12
`define DG_BLANK 5'h13
`define KEY_MENU 0
`define KEY_OK 1
`define KEY_INC 2
`define KEY_DEC 3
`define KEY_SHIFT 4
`define KEY_RUN 5
`define KEY_STOP 6
`define KEY_MF 7
`define CLK_KHZ 10000
`define FAST_HALF_MS 100
`define SLOW_RATIO 5
`endif

// *** panel_pkg.sv ***
// panel_pkg.sv: types of the panel controller
package panel_pkg;
    typedef enum logic [1:0] {lvl_monitor, lvl_group, lvl_code, lvl_value} menu_level_e;
    typedef enum logic [1:0] {src_panel, src_terminal, src_comm} cmd_src_e;
    typedef enum logic [1:0] {mf_off, mf_source, mf_reverse} mf_mode_e;
    typedef logic [4:0] digit_t;
endpackage : panel_pkg

// *** panel_ctrl.sv ***
// panel_ctrl.sv: operation panel keys, three-level menu, lamps and display
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "panel_regs.svh"
module panel_ctrl
    import panel_pkg::*;
#(
    parameter int CODES = 16,
    parameter int MONITORS = 8,
    parameter int FAST_HALF_CYC = `FAST_HALF_MS * `CLK_KHZ,
    parameter int SLOW_RATIO = `SLOW_RATIO
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic menu_level_key,
    input wire logic confirm_key,
    input wire logic increment_key,
    input wire logic decrement_key,
    input wire logic shift_key,
    input wire logic run_key,
    input wire logic stop_key,
    input wire logic multifunction_key,
    input wire logic drive_running,
    input wire logic drive_reverse,
    input wire logic [1:0] cmd_source,
    input wire logic torque_mode,
    input wire logic tuning_active,
    input wire logic fault_active,
    input wire logic [19:0] monitor_data,
    input wire logic [19:0] fault_code,
    input wire logic code_read_only,
    input wire logic code_stop_only,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic run_state_lamp,
    output logic command_source_lamp,
    output logic direction_lamp,
    output logic tune_torque_fault_lamp,
    output logic [24:0] display_digits,
    output logic [4:0] blink_digits,
    output logic [$clog2(MONITORS)-1:0] monitor_sel,
    output logic [4:0] sel_group,
    output logic [$clog2(CODES)-1:0] sel_code,
    output logic run_cmd,
    output logic stop_cmd,
    output logic fault_reset_cmd,
    output logic source_switch_cmd,
    output logic reverse_cmd
);
    localparam int CW = $clog2(CODES);
    localparam int MW = $clog2(MONITORS);
    localparam int DW = $clog2(FAST_HALF_CYC);
    localparam int SW = $clog2(SLOW_RATIO);

    // keys come from pins: two stages, then a press edge
    logic [7:0] key_raw;
    logic [7:0] key_s1_ff;
    logic [7:0] key_s2_ff;
    logic [7:0] key_old_ff;
    logic [7:0] press;
    assign key_raw = {multifunction_key, stop_key, run_key, shift_key,
                      decrement_key, increment_key, confirm_key, menu_level_key};
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_s1_ff <= 8'h00;
            key_s2_ff <= 8'h00;
            key_old_ff <= 8'h00;
        end else begin
            key_s1_ff <= key_raw;
            key_s2_ff <= key_s1_ff;
            key_old_ff <= key_s2_ff;
        end
    end
    assign press = key_s2_ff & ~key_old_ff;
    wire p_menu = press[`KEY_MENU];
    wire p_ok = press[`KEY_OK];
    wire p_inc = press[`KEY_INC];
    wire p_dec = press[`KEY_DEC];
    wire p_shift = press[`KEY_SHIFT];
    wire p_run = press[`KEY_RUN];
    wire p_stop = press[`KEY_STOP];
    wire p_mf = press[`KEY_MF];

    // software settings
    mf_mode_e mf_ff;
    logic [1:0] scope_ff;
    logic [7:0] vis_ff;
    logic [31:0] rdata_ff;
    logic [31:0] rd_mux;
    wire show_a = vis_ff[`VIS_A_BIT];
    wire show_u = vis_ff[`VIS_U_BIT];

    // menu state
    menu_level_e level_ff;
    menu_level_e nxt_level;
    logic [4:0] group_ff;
    logic [4:0] nxt_group;
    logic [CW-1:0] code_ff;
    logic [CW-1:0] nxt_code;
    logic [19:0] edit_ff;
    logic [19:0] nxt_edit;
    logic [2:0] cursor_ff;
    logic [2:0] nxt_cursor;
    logic [MW-1:0] mon_ff;
    logic [MW-1:0] nxt_mon;
    logic mem_we;
    logic [19:0] param_mem [0:`GROUPS-1][0:CODES-1];

    wire in_u = group_ff >= `GRP_U_FIRST;
    wire editable = !in_u && !code_read_only && !(code_stop_only && drive_running);
    wire [CW-1:0] code_up = (code_ff == CW'(CODES - 1)) ? '0 : code_ff + 1'b1;
    wire [CW-1:0] code_dn = (code_ff == '0) ? CW'(CODES - 1) : code_ff - 1'b1;
    wire [MW-1:0] mon_step = (mon_ff == MW'(MONITORS - 1)) ? '0 : mon_ff + 1'b1;
    wire [2:0] cursor_step = (cursor_ff == 3'h4) ? 3'h0 : cursor_ff + 3'h1;

    // hidden families are skipped in both directions
    function automatic logic [4:0] grp_next(input logic [4:0] g, input logic up,
                                           input logic sa, input logic su);
        logic [4:0] c;
        c = 5'h00;
        if (up) begin
            c = (g == `GRP_LAST) ? 5'h00 : g + 5'h01;
            if (c >= `GRP_A_FIRST && c <= `GRP_A_LAST && !sa)
                c = su ? `GRP_U_FIRST : 5'h00;
            if (c >= `GRP_U_FIRST && !su)
                c = 5'h00;
        end else begin
            c = (g == 5'h00) ? `GRP_LAST : g - 5'h01;
            if (c >= `GRP_U_FIRST && !su)
                c = `GRP_A_LAST;
            if (c >= `GRP_A_FIRST && c <= `GRP_A_LAST && !sa)
                c = `GRP_P_LAST;
        end
        return c;
    endfunction : grp_next

    // one digit of the edit value, wrapping within 0 to 9
    function automatic logic [19:0] bump(input logic [19:0] v, input logic [2:0] pos,
                                         input logic up);
        logic [3:0] d;
        logic [19:0] r;
        d = v[pos*4 +: 4];
        r = v;
        if (up)
            r[pos*4 +: 4] = (d == 4'h9) ? 4'h0 : d + 4'h1;
        else
            r[pos*4 +: 4] = (d == 4'h0) ? 4'h9 : d - 4'h1;
        return r;
    endfunction : bump

    // menu keys act one at a time, menu key first
    always_comb begin
        nxt_level = level_ff;
        nxt_group = group_ff;
        nxt_code = code_ff;
        nxt_edit = edit_ff;
        nxt_cursor = cursor_ff;
        nxt_mon = mon_ff;
        mem_we = 1'b0;
        unique case (level_ff)
            lvl_monitor: begin
                if (p_menu)
                    nxt_level = lvl_group;
                else if (p_shift)
                    nxt_mon = mon_step;
            end
            lvl_group: begin
                if (p_menu) begin
                    nxt_level = lvl_monitor;
                end else if (p_ok) begin
                    nxt_level = lvl_code;
                    nxt_code = '0;
                end else if (p_inc) begin
                    nxt_group = grp_next(group_ff, 1'b1, show_a, show_u);
                end else if (p_dec) begin
                    nxt_group = grp_next(group_ff, 1'b0, show_a, show_u);
                end
            end
            lvl_code: begin
                if (p_menu) begin
                    nxt_level = lvl_group;
                end else if (p_ok) begin
                    nxt_level = lvl_value;
                    nxt_edit = param_mem[group_ff][code_ff];
                    nxt_cursor = 3'h0;
                end else if (p_inc) begin
                    nxt_code = code_up;
                end else if (p_dec) begin
                    nxt_code = code_dn;
                end
            end
            lvl_value: begin
                if (p_menu) begin
                    nxt_level = lvl_code;
                end else if (p_ok) begin
                    mem_we = editable;
                    nxt_level = lvl_code;
                    nxt_code = code_up;
                end else if (editable) begin
                    if (p_shift)
                        nxt_cursor = cursor_step;
                    else if (p_inc)
                        nxt_edit = bump(edit_ff, cursor_ff, 1'b1);
                    else if (p_dec)
                        nxt_edit = bump(edit_ff, cursor_ff, 1'b0);
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_ff <= lvl_monitor;
            group_ff <= 5'h00;
            code_ff <= '0;
            edit_ff <= 20'h00000;
            cursor_ff <= 3'h0;
            mon_ff <= '0;
        end else begin
            level_ff <= nxt_level;
            group_ff <= nxt_group;
            code_ff <= nxt_code;
            edit_ff <= nxt_edit;
            cursor_ff <= nxt_cursor;
            mon_ff <= nxt_mon;
        end
    end

    // value store; cleared at reset so every code reads a known value
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int g = 0; g < `GROUPS; g++)
                for (int c = 0; c < CODES; c++)
                    param_mem[g][c] <= 20'h00000;
        end else if (mem_we) begin
            param_mem[group_ff][code_ff] <= edit_ff;
        end
    end

    // group name: letter and hex number
    digit_t grp_letter;
    digit_t grp_num;
    assign grp_letter = (group_ff <= `GRP_P_LAST) ? `DG_P :
                        (group_ff <= `GRP_A_LAST) ? `DG_A : `DG_U;
    assign grp_num = (group_ff <= `GRP_P_LAST) ? group_ff :
                     (group_ff == `GRP_A_LAST) ? `DG_C :
                     (group_ff <= `GRP_A_LAST) ? group_ff - `GRP_A_FIRST :
                     group_ff - `GRP_U_FIRST;
    wire [CW+4:0] code_wide = {5'h00, code_ff};
    wire [4:0] code_tens = 5'(code_wide / 10);
    wire [4:0] code_ones = 5'(code_wide % 10);
    wire [19:0] mon_src = fault_active ? fault_code : monitor_data;

    function automatic logic [24:0] bcd_digits(input logic [19:0] v);
        return {1'b0, v[19:16], 1'b0, v[15:12], 1'b0, v[11:8], 1'b0, v[7:4], 1'b0, v[3:0]};
    endfunction : bcd_digits

    logic [24:0] disp_w;
    always_comb begin
        unique case (level_ff)
            lvl_monitor: disp_w = bcd_digits(mon_src);
            lvl_group: disp_w = {grp_letter, grp_num, `DG_BLANK, `DG_BLANK, `DG_BLANK};
            lvl_code: disp_w = {grp_letter, grp_num, `DG_DASH, code_tens, code_ones};
            lvl_value: disp_w = bcd_digits(edit_ff);
        endcase
    end
    wire [4:0] blink_w = (level_ff == lvl_value && editable) ? 5'h01 << cursor_ff : 5'h00;

    logic [24:0] disp_ff;
    logic [4:0] blink_ff;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            disp_ff <= {5{`DG_BLANK}};
            blink_ff <= 5'h00;
        end else begin
            disp_ff <= disp_w;
            blink_ff <= blink_w;
        end
    end

    // blink clocks: fast half period, slow is a whole number of fast halves
    logic [DW-1:0] div_ff;
    logic [SW-1:0] slow_cnt_ff;
    logic fast_ff;
    logic slow_ff;
    wire tick = div_ff == DW'(FAST_HALF_CYC - 1);
    wire slow_tick = tick && slow_cnt_ff == SW'(SLOW_RATIO - 1);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= '0;
            slow_cnt_ff <= '0;
            fast_ff <= 1'b0;
            slow_ff <= 1'b0;
        end else begin
            div_ff <= tick ? '0 : div_ff + 1'b1;
            if (tick)
                slow_cnt_ff <= slow_tick ? '0 : slow_cnt_ff + 1'b1;
            fast_ff <= fast_ff ^ tick;
            slow_ff <= slow_ff ^ slow_tick;
        end
    end

    // lamps
    logic run_lamp_ff;
    logic src_lamp_ff;
    logic dir_lamp_ff;
    logic tune_lamp_ff;
    wire src_lamp_w = (cmd_source == src_comm) ? slow_ff : (cmd_source == src_terminal);
    wire tune_lamp_w = fault_active ? fast_ff : tuning_active ? slow_ff : torque_mode;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_lamp_ff <= 1'b0;
            src_lamp_ff <= 1'b0;
            dir_lamp_ff <= 1'b0;
            tune_lamp_ff <= 1'b0;
        end else begin
            run_lamp_ff <= drive_running;
            src_lamp_ff <= src_lamp_w;
            dir_lamp_ff <= drive_reverse;
            tune_lamp_ff <= tune_lamp_w;
        end
    end

    // drive commands, one-cycle pulses
    logic run_ff;
    logic stop_ff;
    logic rst_cmd_ff;
    logic src_sw_ff;
    logic rev_ff;
    wire panel_src = cmd_source == src_panel;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_ff <= 1'b0;
            stop_ff <= 1'b0;
            rst_cmd_ff <= 1'b0;
            src_sw_ff <= 1'b0;
            rev_ff <= 1'b0;
        end else begin
            run_ff <= p_run && panel_src;
            stop_ff <= p_stop && drive_running && (panel_src || scope_ff[`SCOPE_ANY_SRC]);
            rst_cmd_ff <= p_stop && fault_active && scope_ff[`SCOPE_RESET_EN];
            src_sw_ff <= p_mf && mf_ff == mf_source;
            rev_ff <= p_mf && mf_ff == mf_reverse;
        end
    end

    // register port; unmapped reads return zero
    always_comb begin
        unique case (reg_addr)
            `REG_MF_SET: rd_mux = {30'h0, mf_ff};
            `REG_STOP_SCOPE: rd_mux = {30'h0, scope_ff};
            `REG_VISIBLE: rd_mux = {24'h0, vis_ff};
            `REG_STATUS: rd_mux = {14'h0, level_ff, 3'h0, group_ff, 8'(code_ff)};
            `REG_EDIT: rd_mux = {12'h0, edit_ff};
            default: rd_mux = 32'h0;
        endcase
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mf_ff <= mf_off;
            scope_ff <= `SCOPE_RESET;
            vis_ff <= `VIS_RESET;
            rdata_ff <= 32'h0;
        end else begin
            if (reg_wr && reg_addr == `REG_MF_SET)
                mf_ff <= (reg_wdata[1:0] == 2'h3) ? mf_off : mf_mode_e'(reg_wdata[1:0]);
            if (reg_wr && reg_addr == `REG_STOP_SCOPE)
                scope_ff <= reg_wdata[1:0];
            if (reg_wr && reg_addr == `REG_VISIBLE)
                vis_ff <= reg_wdata[7:0];
            rdata_ff <= reg_rd ? rd_mux : 32'h0;
        end
    end

    assign reg_rdata = rdata_ff;
    assign run_state_lamp = run_lamp_ff;
    assign command_source_lamp = src_lamp_ff;
    assign direction_lamp = dir_lamp_ff;
    assign tune_torque_fault_lamp = tune_lamp_ff;
    assign display_digits = disp_ff;
    assign blink_digits = blink_ff;
    assign monitor_sel = mon_ff;
    assign sel_group = group_ff;
    assign sel_code = code_ff;
    assign run_cmd = run_ff;
    assign stop_cmd = stop_ff;
    assign fault_reset_cmd = rst_cmd_ff;
    assign source_switch_cmd = src_sw_ff;
    assign reverse_cmd = rev_ff;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence value_confirm_s;
        level_ff == lvl_value && !p_menu && p_ok;
    endsequence
    sequence back_at_code_s;
        level_ff == lvl_code;
    endsequence

    run_lamp_a: assert property (drive_running |=> run_state_lamp)
        else $error("run lamp dark while running");
    src_lamp_a: assert property (panel_src |=> !command_source_lamp)
        else $error("source lamp lit under panel control");
    dir_lamp_a: assert property ($rose(drive_reverse) |=> direction_lamp)
        else $error("direction lamp dark in reverse");
    fault_lamp_a: assert property (fault_active |=> tune_torque_fault_lamp == $past(fast_ff))
        else $error("fault lamp not on fast blink");
    blink_rate_a: assert property ($changed(slow_ff) |-> $changed(fast_ff))
        else $error("slow blink not locked to fast blink");
    menu_toggle_a: assert property (level_ff == lvl_monitor && p_menu |=> level_ff == lvl_group)
        else $error("menu key did not open group level");
    descend_a: assert property (level_ff == lvl_code && !p_menu && p_ok
                                |=> level_ff == lvl_value)
        else $error("confirm did not descend");
    save_next_a: assert property (value_confirm_s ##1 back_at_code_s
                                  |-> sel_code == $past(code_up))
        else $error("confirm did not select next code");
    discard_a: assert property (level_ff == lvl_value && p_menu
                                |=> back_at_code_s and $stable(code_ff))
        else $error("menu key did not keep the code");
    locked_a: assert property (level_ff == lvl_value && !editable
                               |=> blink_digits == 5'h00)
        else $error("locked value shows a blinking digit");
    run_gate_a: assert property (run_cmd |-> $past(cmd_source) == src_panel)
        else $error("run issued outside panel control");
endmodule : panel_ctrl
`default_nettype wire

// *** key_operator.sv ***
// key_operator.sv: operator model pressing one panel key at a time
`timescale 1ns/1ns
`default_nettype none
module key_operator (
    input wire logic core_clk,
    output logic [7:0] keys
);
    initial keys = 8'h00;
    // a released key reads low; the gap after release lets the synchroniser see a new press
    task automatic press(input int k, input int hold);
        @(posedge core_clk);
        keys[k] <= 1'b1;
        repeat (hold) @(posedge core_clk);
        keys[k] <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask : press
endmodule : key_operator
`default_nettype wire

// *** testbench.sv ***
// testbench.sv: self-checking bench of the panel controller
`timescale 1ns/1ns
`default_nettype none
`include "panel_regs.svh"
module testbench
    import panel_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    wire [7:0] keys;
    logic drive_running, drive_reverse, torque_mode, tuning_active, fault_active;
    logic code_read_only, code_stop_only, reg_wr, reg_rd;
    logic [1:0] cmd_source;
    logic [19:0] monitor_data, fault_code;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    wire [31:0] reg_rdata;
    wire [3:0] lamps;
    wire [24:0] display_digits;
    wire [4:0] blink_digits, sel_group, cmds;
    wire [2:0] monitor_sel;
    wire [3:0] sel_code;
    logic [4:0] seen;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;

    key_operator op (.core_clk(core_clk), .keys(keys));
    panel_ctrl #(.FAST_HALF_CYC(4), .SLOW_RATIO(5)) uut (
        .core_clk(core_clk), .rst_n(rst_n),
        .menu_level_key(keys[`KEY_MENU]), .confirm_key(keys[`KEY_OK]),
        .increment_key(keys[`KEY_INC]), .decrement_key(keys[`KEY_DEC]),
        .shift_key(keys[`KEY_SHIFT]), .run_key(keys[`KEY_RUN]),
        .stop_key(keys[`KEY_STOP]), .multifunction_key(keys[`KEY_MF]),
        .drive_running(drive_running), .drive_reverse(drive_reverse),
        .cmd_source(cmd_source), .torque_mode(torque_mode),
        .tuning_active(tuning_active), .fault_active(fault_active),
        .monitor_data(monitor_data), .fault_code(fault_code),
        .code_read_only(code_read_only), .code_stop_only(code_stop_only),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .run_state_lamp(lamps[3]),
        .command_source_lamp(lamps[2]), .direction_lamp(lamps[1]),
        .tune_torque_fault_lamp(lamps[0]), .display_digits(display_digits),
        .blink_digits(blink_digits), .monitor_sel(monitor_sel),
        .sel_group(sel_group), .sel_code(sel_code), .run_cmd(cmds[4]),
        .stop_cmd(cmds[3]), .fault_reset_cmd(cmds[2]),
        .source_switch_cmd(cmds[1]), .reverse_cmd(cmds[0])
    );

    always #50 core_clk = ~core_clk;

    // command pulses last one cycle, so they are gathered here between checks
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        seen <= seen | cmds;
        if (cycles == 4000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task give_verdict();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(reg_rdata, e);
    endtask : rchk

    task cmd(input int k, input logic [4:0] e);
        @(negedge core_clk) seen = 5'h00;
        op.press(k, 1);
        chk({27'h0, seen}, {27'h0, e});
    endtask : cmd

    // counts lamp edges over 100 cycles; fast half period is 4, slow is 20
    task blink(input int b, input int lo, input int hi);
        int n;
        logic p;
        n = 0;
        p = lamps[b];
        repeat (100) begin
            @(negedge core_clk);
            if (lamps[b] !== p) n++;
            p = lamps[b];
        end
        chk({31'h0, n >= lo && n <= hi}, 32'h1);
    endtask : blink

    function automatic logic [31:0] st(menu_level_e l, logic [4:0] g, logic [7:0] c);
        return {14'h0, l, 3'h0, g, c};
    endfunction : st

    initial begin
        {drive_running, drive_reverse, torque_mode, tuning_active, fault_active} = 5'h00;
        {code_read_only, code_stop_only, reg_wr, reg_rd} = 4'h0;
        cmd_source = 2'h0;
        monitor_data = 20'h12345;
        fault_code = 20'h0ABCD;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        seen = 5'h00;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        rchk(`REG_MF_SET, 32'h0);
        rchk(`REG_STOP_SCOPE, 32'h3);
        rchk(`REG_VISIBLE, 32'h11);
        rchk(8'h20, 32'h0);
        chk({7'h0, display_digits}, {7'h0, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05});
        fault_active <= 1'b1;
        blink(0, 24, 26);
        chk({7'h0, display_digits}, {7'h0, 5'h00, 5'h0A, 5'h0B, 5'h0C, 5'h0D});
        fault_active <= 1'b0;
        tuning_active <= 1'b1;
        blink(0, 4, 6);
        {tuning_active, torque_mode, drive_running, drive_reverse} <= 4'h7;
        cmd_source <= 2'h1;
        repeat (3) @(posedge core_clk);
        chk({28'h0, lamps}, 32'hF);
        cmd_source <= 2'h2;
        blink(2, 4, 6);
        {torque_mode, drive_reverse, drive_running} <= 3'h0;
        cmd_source <= 2'h0;
        repeat (3) @(posedge core_clk);
        chk({28'h0, lamps}, 32'h0);
        drive_running <= 1'b1;
        cmd(`KEY_RUN, 5'h10);
        cmd(`KEY_STOP, 5'h08);
        cmd_source <= 2'h1;
        cmd(`KEY_RUN, 5'h00);
        cmd(`KEY_STOP, 5'h08);
        wr(`REG_STOP_SCOPE, 32'h0);
        fault_active <= 1'b1;
        cmd(`KEY_STOP, 5'h00);
        wr(`REG_STOP_SCOPE, 32'h2);
        cmd(`KEY_STOP, 5'h04);
        cmd(`KEY_MF, 5'h00);
        wr(`REG_MF_SET, 32'h1);
        cmd(`KEY_MF, 5'h02);
        wr(`REG_MF_SET, 32'h2);
        cmd(`KEY_MF, 5'h01);
        {fault_active, drive_running} <= 2'h0;
        cmd_source <= 2'h0;
        op.press(`KEY_SHIFT, 1);
        chk({29'h0, monitor_sel}, 32'h1);
        op.press(`KEY_MENU, 6);
        rchk(`REG_STATUS, st(lvl_group, 5'h00, 8'h00));
        wr(`REG_VISIBLE, 32'h01);
        for (int i = 0; i < 14; i++) op.press(`KEY_INC, i % 2 ? 6 : 1);
        rchk(`REG_STATUS, st(lvl_group, 5'h0E, 8'h00));
        op.press(`KEY_INC, 1);
        rchk(`REG_STATUS, st(lvl_group, 5'h19, 8'h00));
        op.press(`KEY_DEC, 1);
        wr(`REG_VISIBLE, 32'h11);
        op.press(`KEY_INC, 1);
        rchk(`REG_STATUS, st(lvl_group, 5'h0F, 8'h00));
        op.press(`KEY_OK, 1);
        op.press(`KEY_INC, 1);
        rchk(`REG_STATUS, st(lvl_code, 5'h0F, 8'h01));
        chk({7'h0, display_digits}, {7'h0, 5'h0A, 5'h00, 5'h12, 5'h00, 5'h01});
        op.press(`KEY_OK, 1);
        rchk(`REG_STATUS, st(lvl_value, 5'h0F, 8'h01));
        chk({27'h0, blink_digits}, 32'h1);
        op.press(`KEY_INC, 1);
        op.press(`KEY_SHIFT, 1);
        chk({27'h0, blink_digits}, 32'h2);
        op.press(`KEY_INC, 1);
        rchk(`REG_EDIT, 32'h11);
        op.press(`KEY_OK, 1);
        rchk(`REG_STATUS, st(lvl_code, 5'h0F, 8'h02));
        op.press(`KEY_DEC, 1);
        op.press(`KEY_OK, 1);
        rchk(`REG_EDIT, 32'h11);
        op.press(`KEY_INC, 1);
        op.press(`KEY_MENU, 1);
        rchk(`REG_STATUS, st(lvl_code, 5'h0F, 8'h01));
        op.press(`KEY_OK, 1);
        rchk(`REG_EDIT, 32'h11);
        {drive_running, code_stop_only} <= 2'h3;
        repeat (3) @(posedge core_clk);
        chk({27'h0, blink_digits}, 32'h0);
        op.press(`KEY_INC, 1);
        rchk(`REG_EDIT, 32'h11);
        op.press(`KEY_MENU, 1);
        {drive_running, code_stop_only, code_read_only} <= 3'h1;
        op.press(`KEY_OK, 1);
        chk({27'h0, blink_digits}, 32'h0);
        op.press(`KEY_MENU, 1);
        op.press(`KEY_MENU, 1);
        op.press(`KEY_MENU, 1);
        op.press(`KEY_SHIFT, 1);
        chk({29'h0, monitor_sel}, 32'h2);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
